//--- design/txctx_ram.sv
`timescale 1ns/1ps
`default_nettype none
module txctx_ram (
  // Clock
  input  wire logic                clk_i,
  // DMA port
  input  wire txctx_pkg::txctx_dma_wr_t dma_i,
  input  wire logic [7:0]          dma_rch_i,
  output logic [191:0]             dma_rctx_o,
  // Host port
  input  wire logic                hwe_i,
  input  wire logic [7:0]          hch_i,
  input  wire logic [1:0]          hbits_i,
  input  wire logic [7:0]          hrch_i,
  output logic [191:0]             hrctx_o
);
  logic [191:0] mem_q [0:txctx_pkg::NUM_CH-1];

  // ****************************************
  // Storage, host write wins over DMA on bits 1:0 of dword 1
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (dma_i.we) begin
      mem_q[dma_i.ch][dma_i.dword*32 +: 32] <= dma_i.data;
    end
    if (hwe_i) begin
      mem_q[hch_i][32 +: txctx_pkg::HOST_WR_BITS] <= hbits_i;
    end
  end

  assign dma_rctx_o = mem_q[dma_rch_i];
  assign hrctx_o    = mem_q[hrch_i];
endmodule
`default_nettype wire

//--- design/txctx_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1: Dword 0 holds current buffer address
// RL2: Enable host-writable, cleared on DMA error
// RL3: Channel reset flag sets enable
// RL4: Done-queue select steers done reporting
// RL5: Error-free status 000, or 001-011 when select
// RL6: Dword 1 bits 3-15 byte count
// RL7: Bits 16, 17 chain-valid and end-of-frame copies
// RL8: Bits 18-19 standard pending pointer validity
// RL9: Bits 20-21 priority pointer validity
// RL10: Bit 22 flags priority packet in progress
// RL11: Unused bits read arbitrary, ignored
// RL12: Dword 2 low: next descriptor offset
// RL13: Dword 2 high: first descriptor offset
// RL14: Dword 3: next and last queued
// RL15: Dwords 4, 5: priority pointers
// RL16: Host writes only dword 1 low
// RL17: Selector 00h-FFh picks channels 1-256
// RL18: Word codes 0-11 pick half-words; code 9 (dword 4 upper) reads zero here
// RL19: Read sets busy until data valid
// RL20: Write copies data, busy until stored
// RL21: Busy read-only, select resets zero
// RL22: Host waits busy low before next
// RL23: Word codes 12-15 reserved, no effect; a read with one loads zero into the data register
module txctx_top (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Host register port
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [11:0]              reg_addr_i,
  input  wire logic [15:0]              reg_wdata_i,
  output logic [15:0]                   reg_rdata_o,
  // DMA engine context port
  input  wire txctx_pkg::txctx_dma_wr_t dma_wr_i,
  input  wire logic                     dma_error_i,
  input  wire logic                     dma_channel_reset_flag_i,
  input  wire logic [7:0]               dma_ev_ch_i,
  input  wire logic [7:0]               dma_rch_i,
  input  wire logic [2:0]               dma_status_i,
  output logic [191:0]                  dma_rctx_o,
  output logic                          dma_enable_o,
  output logic                          dma_dqsel_o,
  output logic [2:0]                    dma_status_o,
  output logic                          status_bad_o
);

  // ****************************************
  // Decode helpers
  // ****************************************
  // Register address match
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] base);
    addr_hit = (a == base);
  endfunction

  // RL11: used bits of a selected half-word
  function automatic logic [15:0] used_bits(input logic [3:0] w);
    if (w == txctx_pkg::WSEL_HOST_WR) begin
      used_bits = txctx_pkg::DW1_LO_USED;
    end else if (w == txctx_pkg::WSEL_D1_UPPER) begin
      used_bits = txctx_pkg::DW1_HI_USED;
    end else begin
      used_bits = 16'hFFFF;
    end
  endfunction

  // ****************************************
  // Host registers
  // ****************************************
  logic [7:0]              ch_q;
  logic [3:0]              wsel_q;
  logic                    rnw_q;
  logic                    busy_q;
  logic [15:0]             data_q;
  logic [15:0]             rdata_q;
  txctx_pkg::txctx_state_t state_q;
  logic                    start;
  logic                    sel_wr;
  logic                    data_wr;

  assign sel_wr  = reg_wr_i && addr_hit(reg_addr_i, txctx_pkg::ADDR_SELECT);
  assign data_wr = reg_wr_i && addr_hit(reg_addr_i, txctx_pkg::ADDR_DATA);
  // RL22: ignore starts while busy
  assign start   = sel_wr && !busy_q;

  // RL21: select register resets to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_q   <= txctx_pkg::SELECT_RST[7:0];
      wsel_q <= txctx_pkg::SELECT_RST[11:8];
      rnw_q  <= txctx_pkg::SELECT_RST[14];
    end else if (start) begin
      // RL17: channel code indexes contexts
      ch_q   <= reg_wdata_i[txctx_pkg::SEL_CH_LSB +: txctx_pkg::CH_W];
      wsel_q <= reg_wdata_i[txctx_pkg::SEL_WORD_LSB +: txctx_pkg::WSEL_W];
      rnw_q  <= reg_wdata_i[txctx_pkg::SEL_RNW_BIT];
    end
  end

  // ****************************************
  // Context storage and word pick
  // ****************************************
  logic [191:0] hctx;
  logic [191:0] hview;
  logic [15:0]  hword;
  logic         hword_ok;
  logic         host_we;
  logic [191:0] dctx;

  // RL16: only dword 1 low word writable
  // RL23: reserved codes never write
  assign host_we = (state_q == txctx_pkg::TXCTX_FETCH) && !rnw_q &&
                   (wsel_q == txctx_pkg::WSEL_HOST_WR);

  // RL1: dwords 0 to 5 held per channel
  txctx_ram u_ram (
    .clk_i      (clk_i),
    .dma_i      (dma_wr_i),
    .dma_rch_i  (dma_rch_i),
    .dma_rctx_o (dctx),
    .hwe_i      (host_we),
    .hch_i      (ch_q),
    .hbits_i    (data_q[txctx_pkg::HOST_WR_BITS-1:0]),
    .hrch_i     (ch_q),
    .hrctx_o    (hctx)
  );

  // RL18: word code picks a half-word, code 9 gives zero
  txctx_wsel u_wsel (
    .ctx_i   (hview),
    .wsel_i  (wsel_q),
    .word_o  (hword),
    .valid_o (hword_ok)
  );

  // ****************************************
  // Indirect access sequencer
  // ****************************************
  // RL19: busy through fetch
  // RL20: busy through store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= txctx_pkg::TXCTX_IDLE;
      busy_q  <= 1'b0;
    end else begin
      case (state_q)
        txctx_pkg::TXCTX_IDLE: begin
          if (start) begin
            state_q <= txctx_pkg::TXCTX_FETCH;
            busy_q  <= 1'b1;
          end
        end
        txctx_pkg::TXCTX_FETCH: begin
          state_q <= txctx_pkg::TXCTX_DONE;
        end
        txctx_pkg::TXCTX_DONE: begin
          state_q <= txctx_pkg::TXCTX_IDLE;
          busy_q  <= 1'b0;
        end
        default: begin
          state_q <= txctx_pkg::TXCTX_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // Data register: host load or fetched word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= txctx_pkg::DATA_RST;
    end else if ((state_q == txctx_pkg::TXCTX_FETCH) && rnw_q) begin
      // RL23: reserved codes return zero
      // RL11: unused bits read as zero
      data_q <= hword_ok ? (hword & used_bits(wsel_q)) : 16'h0000;
    end else if (data_wr && !busy_q) begin
      data_q <= reg_wdata_i;
    end
  end

  // ****************************************
  // Host read data
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_i) begin
      if (addr_hit(reg_addr_i, txctx_pkg::ADDR_SELECT)) begin
        // RL21: busy shown read-only
        rdata_q <= {busy_q, rnw_q, 2'b00, wsel_q, ch_q};
      end else if (addr_hit(reg_addr_i, txctx_pkg::ADDR_DATA)) begin
        rdata_q <= data_q;
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end
  assign reg_rdata_o = rdata_q;

  // ****************************************
  // Per-channel enable and done-queue select
  // ****************************************
  logic [txctx_pkg::NUM_CH-1:0] en_q;
  logic [txctx_pkg::NUM_CH-1:0] dqs_q;

  genvar gi;
  generate
    for (gi = 0; gi < txctx_pkg::NUM_CH; gi++) begin : g_ch
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          en_q[gi]  <= 1'b0;
          dqs_q[gi] <= 1'b0;
        end else begin
          if (host_we && (ch_q == 8'(gi))) begin
            // RL2: host sets or clears enable
            en_q[gi]  <= data_q[txctx_pkg::DW1_ENABLE];
            dqs_q[gi] <= data_q[txctx_pkg::DW1_DQSEL];
          end
          if (dma_ev_ch_i == 8'(gi)) begin
            // RL3: channel reset re-enables
            if (dma_channel_reset_flag_i) begin
              en_q[gi] <= 1'b1;
            // RL2: error disables channel
            end else if (dma_error_i) begin
              en_q[gi] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Host view of the selected context
  // ****************************************
  // RL2: host sees live enable and select
  always_comb begin
    hview = hctx;
    hview[32 + txctx_pkg::DW1_ENABLE] = en_q[ch_q];
    hview[32 + txctx_pkg::DW1_DQSEL]  = dqs_q[ch_q];
  end

  // ****************************************
  // DMA-facing outputs
  // ****************************************
  logic         enable_q;
  logic         dqsel_q;
  logic [2:0]   status_q;
  logic         bad_q;
  logic [191:0] dctx_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= 1'b0;
      dqsel_q  <= 1'b0;
      status_q <= 3'h0;
      bad_q    <= 1'b0;
      dctx_q   <= '0;
    end else begin
      // RL6: byte count, RL7: copies, RL8/RL9/RL10: states via context
      // RL12: RL13: RL14: RL15: pointers carried in context
      dctx_q   <= dctx;
      enable_q <= en_q[dma_rch_i];
      // RL4: per-channel done-queue mode
      dqsel_q  <= dqs_q[dma_rch_i];
      // RL5: packet mode forces 000
      if (!dqs_q[dma_rch_i] && (dma_status_i <= txctx_pkg::DQ_OK_MAX)) begin
        status_q <= txctx_pkg::DQ_OK_PACKET;
        bad_q    <= (dma_status_i != txctx_pkg::DQ_OK_PACKET);
      end else begin
        status_q <= dma_status_i;
        bad_q    <= 1'b0;
      end
    end
  end

  assign dma_rctx_o   = dctx_q;
  assign dma_enable_o = enable_q;
  assign dma_dqsel_o  = dqsel_q;
  assign dma_status_o = status_q;
  assign status_bad_o = bad_q;

endmodule
`default_nettype wire

//--- design/txctx_wsel.sv
`timescale 1ns/1ps
`default_nettype none
module txctx_wsel (
  // Context and selector
  input  wire logic [191:0] ctx_i,
  input  wire logic [3:0]   wsel_i,
  // Selected half-word
  output logic [15:0]       word_o,
  output logic              valid_o
);
  always_comb begin
    word_o  = 16'h0000;
    valid_o = 1'b0;
    if (wsel_i <= txctx_pkg::WSEL_LAST) begin
      valid_o = 1'b1;
      if (wsel_i != txctx_pkg::WSEL_D4_UPPER) begin
        word_o = ctx_i[wsel_i*16 +: 16];
      end
    end
  end
endmodule
`default_nettype wire

//--- inc/txctx_pkg.sv
`default_nettype none
package txctx_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ADDR_SELECT = 12'h870;
  localparam logic [11:0] ADDR_DATA   = 12'h874;
  localparam logic [15:0] SELECT_RST  = 16'h0000;
  localparam logic [15:0] DATA_RST    = 16'h0000;

  // ****************************************
  // Select register fields
  // ****************************************
  localparam int SEL_CH_LSB   = 0;
  localparam int SEL_WORD_LSB = 8;
  localparam int SEL_RNW_BIT  = 14;
  localparam int SEL_BUSY_BIT = 15;

  // ****************************************
  // Context layout
  // ****************************************
  localparam int          NUM_CH        = 256;
  localparam int          CH_W          = 8;
  localparam int          WORDS_PER_CH  = 12;
  localparam int          WSEL_W        = 4;
  localparam logic [3:0]  WSEL_LAST     = 4'hB;
  localparam logic [3:0]  WSEL_HOST_WR  = 4'h2;
  localparam logic [3:0]  WSEL_D4_UPPER = 4'h9;
  localparam logic [3:0]  WSEL_D1_UPPER = 4'h3;
  localparam logic [15:0] DW1_LO_USED   = 16'hFFFB;
  localparam logic [15:0] DW1_HI_USED   = 16'h007F;
  localparam int          HOST_WR_BITS  = 2;
  localparam int          DW1_ENABLE    = 0;
  localparam int          DW1_DQSEL     = 1;
  localparam int          DW1_CNT_LSB   = 3;
  localparam int          DW1_CNT_W     = 13;
  localparam int          DW1_CV        = 16;
  localparam int          DW1_EOF       = 17;
  localparam int          DW1_PEND_LSB  = 18;
  localparam int          DW1_PRI_LSB   = 20;
  localparam int          DW1_PPP       = 22;

  // Done-queue status values without error
  localparam logic [2:0] DQ_OK_PACKET = 3'h0;
  localparam logic [2:0] DQ_OK_MAX    = 3'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        req;
    logic        rnw;
    logic [7:0]  ch;
    logic [3:0]  wsel;
    logic [15:0] wdata;
  } txctx_acc_t;

  typedef struct packed {
    logic        we;
    logic [7:0]  ch;
    logic [2:0]  dword;
    logic [31:0] data;
  } txctx_dma_wr_t;

  typedef enum logic [2:0] {
    TXCTX_IDLE  = 3'b001,
    TXCTX_FETCH = 3'b010,
    TXCTX_DONE  = 3'b100
  } txctx_state_t;

endpackage
`default_nettype wire

//--- tb/txctx_props.sv
`timescale 1ns/1ps
`default_nettype none
module txctx_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Host side
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [15:0] reg_rdata_o,
  // DMA side
  input wire logic        dma_error_i,
  input wire logic        dma_channel_reset_flag_i,
  input wire logic [7:0]  dma_ev_ch_i,
  input wire logic [7:0]  dma_rch_i,
  input wire logic [2:0]  dma_status_i,
  input wire logic        dma_enable_o,
  input wire logic        dma_dqsel_o,
  input wire logic [2:0]  dma_status_o,
  input wire logic        status_bad_o
);
  // Cycles left in an indirect access
  logic [1:0] cnt_q;
  wire        busy   = cnt_q != 2'h0;
  wire        rd_sel = reg_rd_i && reg_addr_i == 12'h870;
  wire        ok_code = dma_status_i inside {[3'h1:3'h3]};
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_q <= 2'h0;
    else if (busy) cnt_q <= cnt_q - 2'h1;
    else if (reg_wr_i && reg_addr_i == 12'h870) cnt_q <= 2'h3;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_busy_during: assert property (rd_sel && cnt_q == 2'h2 |=> reg_rdata_o[15])
    else $error("busy not shown during access");
  a_busy_idle: assert property (rd_sel && !busy |=> !reg_rdata_o[15])
    else $error("busy shown while idle");
  a_sel_gap: assert property (rd_sel |=> reg_rdata_o[13:12] == 2'h0)
    else $error("select gap bits not zero");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
    reg_rdata_o == 16'h0000 && !status_bad_o && !dma_enable_o && !dma_dqsel_o)
    else $error("outputs not cleared by reset");
  a_status_force: assert property (ok_code |=> dma_dqsel_o || dma_status_o == 3'h0)
    else $error("status not forced to zero");
  a_status_pass: assert property (##1 (dma_dqsel_o || $past(dma_status_i) > 3'h3) |-> dma_status_o == $past(dma_status_i))
    else $error("status altered with select set");
  a_status_flag: assert property (ok_code |=> dma_dqsel_o || status_bad_o)
    else $error("forced status not flagged");
  a_err_clear: assert property (dma_error_i && !dma_channel_reset_flag_i && dma_ev_ch_i == dma_rch_i
    |-> ##[1:2] !dma_enable_o)
    else $error("error did not clear enable");
  a_rst_set: assert property (dma_channel_reset_flag_i && dma_ev_ch_i == dma_rch_i |-> ##[1:2] dma_enable_o)
    else $error("channel reset flag did not set enable");
endmodule
bind txctx_top txctx_props txctx_props_i (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o,
  .dma_error_i, .dma_channel_reset_flag_i, .dma_ev_ch_i, .dma_rch_i, .dma_status_i, .dma_enable_o, .dma_dqsel_o,
  .dma_status_o, .status_bad_o);
`default_nettype wire

//--- tb/txctx_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module txctx_top_test;
  logic                     clk_i       = 1'b0;
  logic                     rst_i       = 1'b1;
  logic                     reg_wr_i    = 1'b0;
  logic                     reg_rd_i    = 1'b0;
  logic [11:0]              reg_addr_i  = 12'h000;
  logic [15:0]              reg_wdata_i = 16'h0000;
  logic [15:0]              reg_rdata_o;
  txctx_pkg::txctx_dma_wr_t dma_wr_i    = '0;
  logic                     dma_error_i = 1'b0;
  logic                     dma_channel_reset_flag_i = 1'b0;
  logic [7:0]               dma_ev_ch_i = 8'hFF;
  logic [7:0]               dma_rch_i   = 8'hFF;
  logic [2:0]               dma_status_i = 3'h0;
  logic [191:0]             dma_rctx_o;
  logic                     dma_enable_o;
  logic                     dma_dqsel_o;
  logic [2:0]               dma_status_o;
  logic                     status_bad_o;
  int                       n_mismatch  = 0;
  int                       checked     = 0;
  logic [15:0]              v;
  always #25 clk_i = ~clk_i;
  txctx_top txctx_top_i (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .dma_wr_i, .dma_error_i, .dma_channel_reset_flag_i, .dma_ev_ch_i, .dma_rch_i, .dma_status_i, .dma_rctx_o,
    .dma_enable_o, .dma_dqsel_o, .dma_status_o, .status_bad_o);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] pat(logic [7:0] c, logic [2:0] k);
    return {~c, 2'b00, k, 3'h6, c, 2'b00, k, 3'h4};
  endfunction
  // Unused bits and reserved codes read as zero
  function automatic logic [15:0] ex(logic [7:0] c, logic [3:0] w);
    logic [31:0] d;
    d = pat(c, w[3:1]);
    if (w[3:1] == 3'h1) d = d & 32'h007F_FFFB;
    if (w[3:1] == 3'h4) d = d & 32'h0000_FFFF;
    if (w > 4'hB) d = 32'h0000_0000;
    return w[0] ? d[31:16] : d[15:0];
  endfunction
  task automatic chk(string name, logic [15:0] e, logic [15:0] g);
    checked++;
    if (e !== g) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic rw(logic w, logic [11:0] a, logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  // Start access, poll busy, fetch data on reads
  task automatic acc(logic [7:0] c, logic [3:0] w, logic r);
    rw(1'b1, 12'h870, {1'b0, r, 2'b00, w, c});
    rw(1'b0, 12'h870, 16'h0000);
    chk("busy_first", 16'h8000, v & 16'h8000);
    for (int i = 0; i < 8 && v[15] !== 1'b0; i++) rw(1'b0, 12'h870, 16'h0000);
    chk("busy_end", 16'h0000, v & 16'h8000);
    if (r) rw(1'b0, 12'h874, 16'h0000);
  endtask
  task automatic pulse_ev(logic e, logic s);
    @(posedge clk_i);
    dma_error_i <= e;
    dma_channel_reset_flag_i <= s;
    @(posedge clk_i);
    dma_error_i <= 1'b0;
    dma_channel_reset_flag_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rw(1'b0, 12'h870, 16'h0000);
    chk("select_reset", 16'h0000, v);
    chk("enable_reset", 16'h0000, 16'(dma_enable_o));
  endtask
  task automatic t_words();
    logic [31:0] dw;
    for (int c = 0; c < 2; c++) for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      dma_wr_i <= '{we: 1'b1, ch: 8'(c * 255), dword: 3'(k), data: pat(8'(c * 255), 3'(k))};
    end
    @(posedge clk_i);
    dma_wr_i <= '0;
    repeat (2) @(posedge clk_i);
    #1;
    for (int k = 0; k < 6; k++) begin
      dw = pat(8'hFF, 3'(k));
      chk("dma_ctx_lo", dw[15:0], dma_rctx_o[k*32 +: 16]);
      chk("dma_ctx_hi", dw[31:16], dma_rctx_o[k*32+16 +: 16]);
    end
    for (int c = 0; c < 2; c++) for (int w = 0; w < 16; w++) begin
      acc(8'(c * 255), 4'(w), 1'b1);
      chk("context_word", ex(8'(c * 255), 4'(w)), v);
    end
  endtask
  task automatic t_host_write();
    rw(1'b1, 12'h874, 16'hFFFF);
    acc(8'hFF, 4'h2, 1'b0);
    acc(8'hFF, 4'h0, 1'b0);
    acc(8'hFF, 4'hC, 1'b0);
    acc(8'hFF, 4'h2, 1'b1);
    chk("host_word", ex(8'hFF, 4'h2) | 16'h0003, v);
    chk("enable_out", 16'h0001, 16'(dma_enable_o));
    chk("dqsel_out", 16'h0001, 16'(dma_dqsel_o));
    acc(8'hFF, 4'h0, 1'b1);
    chk("ro_word", ex(8'hFF, 4'h0), v);
    acc(8'hFF, 4'hC, 1'b1);
    chk("reserved_word", 16'h0000, v);
  endtask
  task automatic t_events();
    pulse_ev(1'b1, 1'b0);
    chk("err_clear", 16'h0000, 16'(dma_enable_o));
    acc(8'hFF, 4'h2, 1'b1);
    chk("err_word", ex(8'hFF, 4'h2) | 16'h0002, v);
    pulse_ev(1'b0, 1'b1);
    chk("rst_set", 16'h0001, 16'(dma_enable_o));
    pulse_ev(1'b1, 1'b1);
    chk("rst_wins", 16'h0001, 16'(dma_enable_o));
  endtask
  task automatic t_status();
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 8; s++) begin
        @(posedge clk_i);
        dma_status_i <= 3'(s);
        @(posedge clk_i);
        #1 chk("status", (p == 1 && s > 0 && s < 4) ? 16'h0000 : 16'(s), 16'(dma_status_o));
        chk("status_bad", 16'(p == 1 && s > 0 && s < 4), 16'(status_bad_o));
      end
      rw(1'b1, 12'h874, 16'h0001);
      acc(8'hFF, 4'h2, 1'b0);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_words();
    t_host_write();
    t_events();
    t_status();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
